// ### pkg/addr_mode_pkg.sv
package addr_mode_pkg;

    // Addressing modes as resolved from the opcode by the caller.
    typedef enum logic [2:0] {
        accumulator_only_mode,
        mode_immediate,
        mode_direct,
        mode_extended,
        mode_indexed,
        mode_implied,
        mode_relative
    } addr_mode_t;

    // Instruction lengths in bytes.
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;

    // Bus cycles spent on address formation beyond the opcode fetch.
    localparam logic [2:0] CYC_DIRECT = 3'h1;
    localparam logic [2:0] CYC_EXTENDED = 3'h2;
    localparam logic [2:0] CYC_INDEXED = 3'h2;

    // Relative base is the address of the byte after the branch.
    localparam logic [15:0] REL_BASE_OFS = 16'h0002;

    // Reset values.
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Split-byte address add: low byte plus offset, carry or borrow
    // folded into the high byte afterwards.
    function automatic logic [15:0] byte_add(input logic [15:0] base,
                                             input logic [7:0] ofs,
                                             input logic signed_ofs);
        logic [8:0] low_sum;
        logic [7:0] high_adj;
        low_sum = {1'b0, base[7:0]} + {1'b0, ofs};
        high_adj = base[15:8];
        if (signed_ofs && ofs[7]) begin
            if (!low_sum[8]) begin
                high_adj = base[15:8] - 8'h01;
            end
        end else if (low_sum[8]) begin
            high_adj = base[15:8] + 8'h01;
        end
        return {high_adj, low_sum[7:0]};
    endfunction : byte_add

endpackage : addr_mode_pkg

// ### design/operand_byte_capture.sv
`timescale 1ns/1ps
module operand_byte_capture
    import addr_mode_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic load_second,
    input wire logic load_third,
    input wire logic [7:0] data_in,
    output logic [7:0] second_byte,
    output logic [7:0] third_byte
);

    // Instruction bytes are kept for the whole address phase.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            second_byte <= BYTE_RESET;
        end else if (load_second) begin
            second_byte <= data_in;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            third_byte <= BYTE_RESET;
        end else if (load_third) begin
            third_byte <= data_in;
        end
    end

endmodule : operand_byte_capture

// ### design/temp_address_register.sv
`timescale 1ns/1ps
module temp_address_register
    import addr_mode_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic load,
    input wire logic [15:0] addr_in,
    output logic [15:0] addr_out
);

    // A private copy, so the index register itself is never written.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            addr_out <= ADDR_RESET;
        end else if (load) begin
            addr_out <= addr_in;
        end
    end

endmodule : temp_address_register

// ### design/operand_address_generator.sv
`timescale 1ns/1ps
// What this block does
// RQ1: Accumulator mode: opcode picks A or B, one byte.
// RQ2: Immediate operand is byte two, or bytes two-three.
// RQ3: Immediate length two or three; PC advances so.
// RQ4: Immediate operand read in stream, no operand address.
// RQ5: Direct address is byte two, high byte zero.
// RQ6: Direct reaches 0..255, faster than extended.
// RQ7: Extended: byte two high, byte three low, three bytes.
// RQ8: Indexed: offset plus index low, carry to high.
// RQ9: Indexed address in temporary register; index untouched.
// RQ10: Implied: opcode names the register, one byte.
// RQ11: Relative: offset plus PC plus two, carry adjusts.
// RQ12: Branch targets span -126 to +129 of instruction.
// RQ13: Relative offset is signed two's complement.
module operand_address_generator
    import addr_mode_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    input addr_mode_t mode,
    input wire logic acc_select_b,
    input wire logic wide_immediate,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] index_in,
    input wire logic [7:0] data_in,
    output logic busy,
    output logic done,
    output logic [15:0] fetch_addr,
    output logic fetch_valid,
    output logic [15:0] operand_addr,
    output logic operand_addr_valid,
    output logic [15:0] immediate_data,
    output logic immediate_valid,
    output logic use_acc_b,
    output logic acc_operand,
    output logic [1:0] instr_length,
    output logic [15:0] next_pc,
    output logic [2:0] addr_cycles
);

    typedef enum logic [2:0] {
        st_idle,
        st_byte2,
        st_byte3,
        st_calc,
        st_finish
    } gen_state_t;

    gen_state_t state_q;
    gen_state_t state_d;
    addr_mode_t mode_q;
    logic acc_b_q;
    logic wide_q;
    logic [15:0] pc_q;
    logic [15:0] index_q;
    logic [15:0] fetch_q;
    logic [1:0] len_q;
    logic [2:0] cycles_q;
    logic [15:0] opaddr_q;
    logic opaddr_valid_q;
    logic [15:0] imm_q;
    logic imm_valid_q;
    logic acc_q;
    logic done_q;
    logic [15:0] next_pc_q;
    logic load_second;
    logic load_third;
    logic [7:0] second_byte;
    logic [7:0] third_byte;
    logic temp_load;
    logic [15:0] temp_addr;
    logic [15:0] temp_in;

    // Bytes two and three are latched on the fetch cycles that read them.
    assign load_second = (state_q == st_byte2);
    assign load_third = (state_q == st_byte3);

    operand_byte_capture u_bytes (
        .clock(clock),
        .resetn(resetn),
        .load_second(load_second),
        .load_third(load_third),
        .data_in(data_in),
        .second_byte(second_byte),
        .third_byte(third_byte)
    );

    // Only the indexed and relative sums go through the temporary
    // register; the index input is only ever read here.
    assign temp_load = (state_q == st_calc);
    always_comb begin
        temp_in = ADDR_RESET;
        if (mode_q == mode_indexed) begin
            temp_in = byte_add(index_q, second_byte, 1'b0); // [RQ8] [RQ9]
        end else if (mode_q == mode_relative) begin
            // Signed offset from PC plus two spans -126..+129. [RQ12]
            temp_in = byte_add(pc_q + REL_BASE_OFS, second_byte,
                               1'b1); // [RQ11] [RQ13]
        end
    end

    temp_address_register u_temp (
        .clock(clock),
        .resetn(resetn),
        .load(temp_load),
        .addr_in(temp_in),
        .addr_out(temp_addr)
    );

    // Sequencer: one state per extra instruction byte, then a calc
    // cycle for the modes that need an add.
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_idle: begin
                if (start) begin
                    if (mode == accumulator_only_mode ||
                        mode == mode_implied) begin
                        state_d = st_finish; // [RQ1] [RQ10]
                    end else begin
                        state_d = st_byte2;
                    end
                end
            end
            st_byte2: begin
                if (mode_q == mode_extended ||
                    (mode_q == mode_immediate && wide_q)) begin
                    state_d = st_byte3;
                end else if (mode_q == mode_indexed ||
                             mode_q == mode_relative) begin
                    state_d = st_calc;
                end else begin
                    state_d = st_finish;
                end
            end
            st_byte3: state_d = st_finish;
            st_calc: state_d = st_finish;
            st_finish: state_d = st_idle;
            default: state_d = st_idle;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    // Request context is frozen at start so callers may change inputs.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_q <= accumulator_only_mode;
            acc_b_q <= 1'b0;
            wide_q <= 1'b0;
            pc_q <= ADDR_RESET;
            index_q <= ADDR_RESET;
        end else if (state_q == st_idle && start) begin
            mode_q <= mode;
            acc_b_q <= acc_select_b;
            wide_q <= wide_immediate;
            pc_q <= pc_in;
            index_q <= index_in;
        end
    end

    // Instruction stream address: PC+1 then PC+2, operand bytes read
    // in line with the instruction itself.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fetch_q <= ADDR_RESET;
        end else if (state_q == st_idle && start) begin
            fetch_q <= pc_in + 16'h0001;
        end else if (state_q == st_byte2) begin
            fetch_q <= fetch_q + 16'h0001;
        end
    end

    assign fetch_addr = fetch_q;
    assign fetch_valid = (state_q == st_byte2) || (state_q == st_byte3);

    // Length and address-phase cycle count per mode.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            len_q <= LEN_ONE;
            cycles_q <= 3'h0;
        end else if (state_q == st_idle && start) begin
            case (mode)
                accumulator_only_mode: begin
                    len_q <= LEN_ONE; // [RQ1]
                    cycles_q <= 3'h0;
                end
                mode_implied: begin
                    len_q <= LEN_ONE; // [RQ10]
                    cycles_q <= 3'h0;
                end
                mode_immediate: begin
                    len_q <= wide_immediate ? LEN_THREE : LEN_TWO; // [RQ3]
                    cycles_q <= 3'h0; // [RQ4]
                end
                mode_direct: begin
                    len_q <= LEN_TWO; // [RQ5]
                    cycles_q <= CYC_DIRECT; // [RQ6]
                end
                mode_extended: begin
                    len_q <= LEN_THREE; // [RQ7]
                    cycles_q <= CYC_EXTENDED; // [RQ6]
                end
                mode_indexed: begin
                    len_q <= LEN_TWO; // [RQ8]
                    cycles_q <= CYC_INDEXED;
                end
                mode_relative: begin
                    len_q <= LEN_TWO; // [RQ11]
                    cycles_q <= 3'h0;
                end
                default: begin
                    len_q <= LEN_ONE;
                    cycles_q <= 3'h0;
                end
            endcase
        end
    end

    // The next-PC length decode is a function of its own; the instr_length
    // register and the sequencer each decode the mode separately.
    function automatic logic [1:0] instr_len(input addr_mode_t m,
                                             input logic wide);
        logic [1:0] len;
        len = LEN_TWO;
        if (m == accumulator_only_mode || m == mode_implied) begin
            len = LEN_ONE; // [RQ1] [RQ10]
        end else if (m == mode_extended ||
                     (m == mode_immediate && wide)) begin
            len = LEN_THREE; // [RQ3] [RQ7]
        end
        return len;
    endfunction : instr_len

    // Next PC is formed at the taking edge from the incoming PC, so the
    // output comes straight from a register rather than from an adder.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            next_pc_q <= ADDR_RESET + {14'h0000, LEN_ONE};
        end else if (state_q == st_idle && start) begin
            next_pc_q <= pc_in + {14'h0000,
                                  instr_len(mode, wide_immediate)}; // [RQ3]
        end
    end

    // Results are registered on the finish cycle and held until the
    // next start, so a slow consumer still sees them.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            opaddr_q <= ADDR_RESET;
            opaddr_valid_q <= 1'b0;
            imm_q <= ADDR_RESET;
            imm_valid_q <= 1'b0;
            acc_q <= 1'b0;
        end else if (state_q == st_idle && start) begin
            opaddr_valid_q <= 1'b0;
            imm_valid_q <= 1'b0;
            acc_q <= 1'b0;
        end else if (state_q == st_finish) begin
            case (mode_q)
                accumulator_only_mode: begin
                    acc_q <= 1'b1; // [RQ1]
                end
                mode_immediate: begin
                    imm_q <= wide_q ? {second_byte, third_byte}
                                    : {8'h00, second_byte}; // [RQ2] [RQ4]
                    imm_valid_q <= 1'b1;
                end
                mode_direct: begin
                    opaddr_q <= {8'h00, second_byte}; // [RQ5] [RQ6]
                    opaddr_valid_q <= 1'b1;
                end
                mode_extended: begin
                    opaddr_q <= {second_byte, third_byte}; // [RQ7]
                    opaddr_valid_q <= 1'b1;
                end
                mode_indexed: begin
                    opaddr_q <= temp_addr; // [RQ9]
                    opaddr_valid_q <= 1'b1;
                end
                mode_relative: begin
                    opaddr_q <= temp_addr; // [RQ11]
                    opaddr_valid_q <= 1'b1;
                end
                default: begin
                    opaddr_valid_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == st_finish);
        end
    end

    assign busy = (state_q != st_idle);
    assign done = done_q;
    assign operand_addr = opaddr_q;
    assign operand_addr_valid = opaddr_valid_q;
    assign immediate_data = imm_q;
    assign immediate_valid = imm_valid_q;
    assign use_acc_b = acc_b_q;
    assign acc_operand = acc_q;
    assign instr_length = len_q;
    // PC moves past the whole instruction whatever the mode. [RQ3]
    assign next_pc = next_pc_q;
    assign addr_cycles = cycles_q;

endmodule : operand_address_generator

// ### test/operand_address_generator_assertions.sv
`timescale 1ns/1ps
module operand_address_generator_assertions
    import addr_mode_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    input addr_mode_t mode,
    input wire logic wide_immediate,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] index_in,
    input wire logic [7:0] data_in,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic [15:0] operand_addr,
    input wire logic operand_addr_valid,
    input wire logic immediate_valid,
    input wire logic acc_operand,
    input wire logic [1:0] instr_length,
    input wire logic [15:0] next_pc,
    input wire logic [2:0] addr_cycles
);
    addr_mode_t mode_q;
    logic wide_q;
    logic [15:0] pc_q;
    logic [15:0] idx_q;
    logic [7:0] b2_q;
    wire logic take = start && !busy;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Inputs may move after the taking edge, so the request is kept here.
    always_ff @(posedge clock) begin
        if (take) begin
            mode_q <= mode;
            wide_q <= wide_immediate;
            pc_q <= pc_in;
            idx_q <= index_in;
        end
    end
    // The second byte is whatever is read from the address after the opcode.
    always_ff @(posedge clock) begin
        if (fetch_valid && fetch_addr == pc_q + 16'h0001) begin
            b2_q <= data_in;
        end
    end
    property p_acc;
        take && mode == accumulator_only_mode |=> !fetch_valid ##1
            (done && acc_operand && instr_length == LEN_ONE);
    endproperty
    a_acc: assert property (p_acc) else $error("bad accumulator op");
    property p_impl;
        take && mode == mode_implied |=> ##1
            (done && !operand_addr_valid && instr_length == LEN_ONE);
    endproperty
    a_impl: assert property (p_impl) else $error("bad implied op");
    property p_imm;
        done && mode_q == mode_immediate |-> immediate_valid &&
            !operand_addr_valid &&
            instr_length == (wide_q ? LEN_THREE : LEN_TWO);
    endproperty
    a_imm: assert property (p_imm) else $error("bad immediate");
    property p_pc;
        done |-> next_pc == pc_q + ((mode_q == accumulator_only_mode ||
            mode_q == mode_implied) ? 16'h0001 : (mode_q == mode_extended ||
            (mode_q == mode_immediate && wide_q)) ? 16'h0003 : 16'h0002);
    endproperty
    a_pc: assert property (p_pc) else $error("bad next pc");
    property p_dir;
        done && mode_q == mode_direct |->
            operand_addr == {8'h00, b2_q} && addr_cycles == CYC_DIRECT;
    endproperty
    a_dir: assert property (p_dir) else $error("bad direct");
    // Direct must finish one cycle ahead of the extended sequence below.
    property p_fast;
        take && mode == mode_direct |=> busy && fetch_valid &&
            fetch_addr == pc_q + 16'h0001 ##1 busy && !fetch_valid
            ##1 done && !busy;
    endproperty
    a_fast: assert property (p_fast) else $error("slow direct");
    property p_ext;
        take && mode == mode_extended |=>
            fetch_valid && fetch_addr == pc_q + 16'h0001 ##1
            fetch_valid && fetch_addr == pc_q + 16'h0002 ##1 !fetch_valid
            ##1 done && addr_cycles == CYC_EXTENDED;
    endproperty
    a_ext: assert property (p_ext) else $error("bad extended");
    property p_idx;
        done && mode_q == mode_indexed |->
            operand_addr == idx_q + {8'h00, b2_q};
    endproperty
    a_idx: assert property (p_idx) else $error("bad indexed");
    property p_rel;
        done && mode_q == mode_relative |-> operand_addr ==
            pc_q + REL_BASE_OFS + {{8{b2_q[7]}}, b2_q};
    endproperty
    a_rel: assert property (p_rel) else $error("bad relative");
    c_rel: cover property (done && mode_q == mode_relative);
    c_ext: cover property (done && mode_q == mode_extended);
    c_wide: cover property (done && mode_q == mode_immediate && wide_q);
endmodule : operand_address_generator_assertions
bind operand_address_generator
    operand_address_generator_assertions checker_i (
        .clock(clock),
        .resetn(resetn),
        .start(start),
        .mode(mode),
        .wide_immediate(wide_immediate),
        .pc_in(pc_in),
        .index_in(index_in),
        .data_in(data_in),
        .busy(busy),
        .done(done),
        .fetch_addr(fetch_addr),
        .fetch_valid(fetch_valid),
        .operand_addr(operand_addr),
        .operand_addr_valid(operand_addr_valid),
        .immediate_valid(immediate_valid),
        .acc_operand(acc_operand),
        .instr_length(instr_length),
        .next_pc(next_pc),
        .addr_cycles(addr_cycles)
    );

// ### test/program_memory.sv
`timescale 1ns/1ps
module program_memory (
    input wire logic clock,
    input wire logic [15:0] fetch_addr,
    input wire logic fetch_valid,
    output logic [7:0] data_in
);
    logic [7:0] mem [256];
    logic [7:0] last_q;
    // Bytes come only in fetch cycles; otherwise the inverse of the last one
    // shows, so a late sample cannot pass by luck.
    always_comb begin
        if (fetch_valid) begin
            data_in = mem[fetch_addr[7:0]];
        end else begin
            data_in = ~last_q;
        end
    end
    // The last served byte feeds the idle pattern.
    always_ff @(posedge clock) begin
        if (fetch_valid) begin
            last_q <= data_in;
        end
    end
endmodule : program_memory

// ### test/test_operand_address_generator.sv
`timescale 1ns/1ps
module test_operand_address_generator import addr_mode_pkg::*;;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    addr_mode_t mode = accumulator_only_mode;
    logic acc_select_b = 1'b0;
    logic wide_immediate = 1'b0;
    logic [15:0] pc_in = 16'h0000;
    logic [15:0] index_in = 16'h0000;
    logic [7:0] data_in;
    logic busy, done, fetch_valid, operand_addr_valid, immediate_valid;
    logic use_acc_b, acc_operand;
    logic [15:0] fetch_addr, operand_addr, immediate_data, next_pc;
    logic [1:0] instr_length;
    logic [2:0] addr_cycles;
    logic [63:0] seen;
    logic [63:0] exp_q [$];
    int n_fail = 0;
    int checks_done = 0;
    int seed = 80501;
    operand_address_generator operand_address_generator_i (
        .clock(clock),
        .resetn(resetn),
        .start(start),
        .mode(mode),
        .acc_select_b(acc_select_b),
        .wide_immediate(wide_immediate),
        .pc_in(pc_in),
        .index_in(index_in),
        .data_in(data_in),
        .busy(busy),
        .done(done),
        .fetch_addr(fetch_addr),
        .fetch_valid(fetch_valid),
        .operand_addr(operand_addr),
        .operand_addr_valid(operand_addr_valid),
        .immediate_data(immediate_data),
        .immediate_valid(immediate_valid),
        .use_acc_b(use_acc_b),
        .acc_operand(acc_operand),
        .instr_length(instr_length),
        .next_pc(next_pc),
        .addr_cycles(addr_cycles)
    );
    program_memory program_memory_i (
        .clock(clock),
        .fetch_addr(fetch_addr),
        .fetch_valid(fetch_valid),
        .data_in(data_in)
    );
    initial forever #5 clock = ~clock;
    task automatic check(input logic [63:0] got, input logic [63:0] want);
        checks_done++;
        if (got !== want) begin
            n_fail++;
            $display("unexpected at %0t: seen %h, expected %h", $time, got,
                     want);
        end
    endtask : check
    task automatic results;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // One request; a held start must be refused while busy.
    task automatic op(input addr_mode_t m, input logic b, input logic w,
                      input logic [15:0] pc, input logic [15:0] ix,
                      input logic hold);
        logic [15:0] a1 = pc + 16'h0001;
        logic [15:0] a2 = pc + 16'h0002;
        logic [7:0] b2 = program_memory_i.mem[a1[7:0]];
        logic [7:0] b3 = program_memory_i.mem[a2[7:0]];
        logic [15:0] oa = 16'h0000;
        logic [15:0] im = 16'h0000;
        logic [1:0] len = LEN_TWO;
        logic [2:0] cyc = 3'h0;
        logic ov = m inside {mode_direct, mode_extended, mode_indexed,
                             mode_relative};
        case (m)
            accumulator_only_mode, mode_implied: len = LEN_ONE;
            mode_immediate: begin
                im = w ? {b2, b3} : {8'h00, b2};
                len = w ? LEN_THREE : LEN_TWO;
            end
            mode_direct: begin
                oa = {8'h00, b2};
                cyc = CYC_DIRECT;
            end
            mode_extended: begin
                oa = {b2, b3};
                len = LEN_THREE;
                cyc = CYC_EXTENDED;
            end
            mode_indexed: begin
                oa = ix + {8'h00, b2};
                cyc = CYC_INDEXED;
            end
            default: oa = a2 + {{8{b2[7]}}, b2};
        endcase
        exp_q.push_back({7'h00, oa, ov, im, m == mode_immediate,
            m == accumulator_only_mode, b, len, pc + {14'h0000, len}, cyc});
        start <= 1'b1;
        mode <= m;
        acc_select_b <= b;
        wide_immediate <= w;
        pc_in <= pc;
        index_in <= ix;
        @(posedge clock);
        if (hold) @(posedge clock);
        start <= 1'b0;
        for (int i = 0; i < 12 && exp_q.size() > 0; i++) @(posedge clock);
        if (exp_q.size() > 0) check(64'h1, 64'h0);
        exp_q.delete();
    endtask : op
    // Every done pulse is matched against the oldest noted result.
    always @(negedge clock) begin
        if (done === 1'b1) begin
            seen = {7'h00, operand_addr_valid ? operand_addr : 16'h0000,
                operand_addr_valid,
                immediate_valid ? immediate_data : 16'h0000,
                immediate_valid, acc_operand, use_acc_b, instr_length,
                next_pc, addr_cycles};
            if (exp_q.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                check(seen, exp_q.pop_front());
            end
        end
    end
    initial begin
        for (int i = 0; i < 256; i++) begin
            program_memory_i.mem[i] = 8'($random(seed));
        end
        // Page crossings with carry and borrow, and the offset extremes.
        program_memory_i.mem[8'hFF] = 8'hFF;
        program_memory_i.mem[8'h01] = 8'h80;
        program_memory_i.mem[8'hF1] = 8'h7F;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        op(mode_relative, 1'b0, 1'b0, 16'h12FE, 16'h0000, 1'b0);
        op(mode_relative, 1'b1, 1'b0, 16'h1200, 16'h0000, 1'b1);
        op(mode_relative, 1'b0, 1'b1, 16'h12F0, 16'h0000, 1'b0);
        op(mode_indexed, 1'b0, 1'b0, 16'h12FE, 16'h00FF, 1'b0);
        op(mode_direct, 1'b1, 1'b0, 16'h12FE, 16'h0000, 1'b0);
        for (int i = 0; i < 80; i++) begin
            op(addr_mode_t'(3'($unsigned($random(seed)) % 7)),
               1'($random(seed)), 1'($random(seed)), 16'($random(seed)),
               16'($random(seed)), ($random(seed) & 3) == 0);
        end
        // A reset in mid-run brings the length back to one byte.
        resetn <= 1'b0;
        @(negedge clock);
        check({61'h0, done, instr_length}, {61'h0, 1'b0, LEN_ONE});
        @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        op(mode_extended, 1'b0, 1'b0, 16'hFFFE, 16'h0000, 1'b0);
        results();
    end
    // A hang is cut short well after the expected run length.
    initial begin
        #50000;
        n_fail++;
        results();
    end
endmodule : test_operand_address_generator
